// ### design/p0g_port.sv
/*
 * seven-pin general purpose port with control mode, edge interrupts and
 * serial receive pin switching, on a classic wishbone slave.
 * assumes pads turn pin_o/pin_oe_o/pullup_en_o into the wire; pin_i async.
 */
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "p0g_defs.svh"

module p0g_port (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire p0g_pkg::p0g_addr_t adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire p0g_pkg::p0g_word_t dat_i,
    output p0g_pkg::p0g_word_t     dat_o,
    output logic                   ack_o,
    // pins
    input  wire p0g_pkg::p0g_bits_t pin_i,
    output p0g_pkg::p0g_bits_t     pin_o,
    output p0g_pkg::p0g_bits_t     pin_oe_o,
    output p0g_pkg::p0g_bits_t     pullup_en_o,
    // alternate functions
    output p0g_pkg::p0g_bits_t     ext_irq_pulse_o,
    output logic                   serial_rx_o,
    output logic                   sampling_clock_o,
    output logic                   irq_o
);
    import p0g_pkg::*;

    p0g_bits_t dir_q;
    p0g_bits_t pullup_q;
    p0g_bits_t mode_q;
    p0g_bits_t out_q;
    p0g_bits_t rise_q;
    p0g_bits_t fall_q;
    logic      rxsel_q;
    p0g_bits_t stat_q;
    p0g_bits_t mask_q;
    p0g_bits_t level;
    p0g_bits_t pulse;
    logic      ack_q;
    p0g_word_t dat_q;
    p0g_word_t rd_d;
    logic      wr_en;
    logic      rx_q;
    logic      smp_q;

    // ****************************************
    // bus handshake
    // ****************************************
    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'h0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    // writes land on the edge where the master sees ack
    assign wr_en = cyc_i & stb_i & we_i & ack_q & sel_i[0];
    assign ack_o = ack_q;

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (adr_i)
            `P0G_OFS_DIR:    rd_d[`P0G_NPINS-1:0] = dir_q;
            `P0G_OFS_PULLUP: rd_d[`P0G_NPINS-1:0] = pullup_q;
            `P0G_OFS_MODE:   rd_d[`P0G_NPINS-1:0] = mode_q;
            `P0G_OFS_OUT:    rd_d[`P0G_NPINS-1:0] = out_q;
            `P0G_OFS_PIN:    rd_d[`P0G_NPINS-1:0] = level;
            `P0G_OFS_RISE:   rd_d[`P0G_NPINS-1:0] = rise_q;
            `P0G_OFS_FALL:   rd_d[`P0G_NPINS-1:0] = fall_q;
            `P0G_OFS_RXSEL:  rd_d[0]              = rxsel_q;
            `P0G_OFS_STAT:   rd_d[`P0G_NPINS-1:0] = stat_q;
            `P0G_OFS_MASK:   rd_d[`P0G_NPINS-1:0] = mask_q;
            default:         rd_d = 32'h0000_0000;
        endcase
    end

    // captured on the request edge so it stands still during ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~we_i & ~ack_q) begin
            dat_q <= rd_d;
        end
    end

    assign dat_o = dat_q;

    // ****************************************
    // port configuration
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= `P0G_RST_DIR;
        end else if (wr_en && adr_i == `P0G_OFS_DIR) begin
            dir_q <= dat_i[`P0G_NPINS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_q <= `P0G_RST_PULLUP;
        end else if (wr_en && adr_i == `P0G_OFS_PULLUP) begin
            pullup_q <= dat_i[`P0G_NPINS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= `P0G_RST_MODE;
        end else if (wr_en && adr_i == `P0G_OFS_MODE) begin
            mode_q <= dat_i[`P0G_NPINS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= `P0G_RST_OUT;
        end else if (wr_en && adr_i == `P0G_OFS_OUT) begin
            out_q <= dat_i[`P0G_NPINS-1:0];
        end
    end

    // ****************************************
    // edge selection
    // ****************************************
    // both bits set gives both edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_q <= `P0G_RST_RISE;
            fall_q <= `P0G_RST_FALL;
        end else if (wr_en) begin
            if (adr_i == `P0G_OFS_RISE) begin
                rise_q <= dat_i[`P0G_NPINS-1:0];
            end
            if (adr_i == `P0G_OFS_FALL) begin
                fall_q <= dat_i[`P0G_NPINS-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxsel_q <= `P0G_RST_RXSEL;
        end else if (wr_en && adr_i == `P0G_OFS_RXSEL) begin
            rxsel_q <= dat_i[0];
        end
    end

    // ****************************************
    // per-pin synchronisers and edge detectors
    // ****************************************
    generate
        for (genvar i = 0; i < `P0G_NPINS; i++) begin : g_pin
            p0g_edge_det u_edge (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .pin_i     (pin_i[i]),
                .en_i      (mode_q[i]),
                .rise_en_i (rise_q[i]),
                .fall_en_i (fall_q[i]),
                .level_o   (level[i]),
                .pulse_o   (pulse[i])
            );
        end
    endgenerate

    assign ext_irq_pulse_o = pulse;

    // ****************************************
    // pin drivers
    // ****************************************
    // control mode functions are all inputs, so the driver is off there
    assign pin_oe_o    = ~dir_q & ~mode_q;
    assign pin_o       = out_q;
    assign pullup_en_o = pullup_q;

    // ****************************************
    // serial receive and sampling clock
    // ****************************************
    // idle high when the chosen pin is not in control mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_q <= `P0G_RX_IDLE;
        end else if (rxsel_q) begin
            rx_q <= mode_q[`P0G_PIN_RX_ALT] ? level[`P0G_PIN_RX_ALT] : `P0G_RX_IDLE;
        end else begin
            rx_q <= mode_q[`P0G_PIN_RX_PRI] ? level[`P0G_PIN_RX_PRI] : `P0G_RX_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smp_q <= 1'h0;
        end else begin
            smp_q <= mode_q[`P0G_PIN_SMP] & level[`P0G_PIN_SMP];
        end
    end

    assign serial_rx_o      = rx_q;
    assign sampling_clock_o = smp_q;

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // set beats a simultaneous write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= `P0G_RST_STAT;
        end else if (wr_en && adr_i == `P0G_OFS_STAT) begin
            stat_q <= (stat_q & ~dat_i[`P0G_NPINS-1:0]) | pulse;
        end else begin
            stat_q <= stat_q | pulse;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `P0G_RST_MASK;
        end else if (wr_en && adr_i == `P0G_OFS_MASK) begin
            mask_q <= dat_i[`P0G_NPINS-1:0];
        end
    end

    assign irq_o = |(stat_q & mask_q);

endmodule : p0g_port

`default_nettype wire

// ### include/p0g_defs.svh
/*
 * register offsets, reset values and widths of the seven-pin port block.
 * assumes byte addressing on a 32-bit classic wishbone bus.
 */
`ifndef P0G_DEFS_SVH
`define P0G_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define P0G_NPINS          7
`define P0G_AW             6

// ****************************************
// register byte offsets
// ****************************************
`define P0G_OFS_DIR        6'h00
`define P0G_OFS_PULLUP     6'h04
`define P0G_OFS_MODE       6'h08
`define P0G_OFS_OUT        6'h0c
`define P0G_OFS_PIN        6'h10
`define P0G_OFS_RISE       6'h14
`define P0G_OFS_FALL       6'h18
`define P0G_OFS_RXSEL      6'h1c
`define P0G_OFS_STAT       6'h20
`define P0G_OFS_MASK       6'h24

// ****************************************
// reset values
// ****************************************
`define P0G_RST_DIR        7'h7f
`define P0G_RST_PULLUP     7'h00
`define P0G_RST_MODE       7'h00
`define P0G_RST_OUT        7'h00
`define P0G_RST_RISE       7'h00
`define P0G_RST_FALL       7'h00
`define P0G_RST_RXSEL      1'h0
`define P0G_RST_STAT       7'h00
`define P0G_RST_MASK       7'h00

// ****************************************
// pin assignment in control mode
// ****************************************
`define P0G_PIN_RX_PRI     5
`define P0G_PIN_RX_ALT     6
`define P0G_PIN_SMP        5
`define P0G_RX_IDLE        1'h1

`endif

// ### include/p0g_pkg.sv
/*
 * types shared by the seven-pin port block.
 * assumes p0g_defs.svh is on the include path.
 */
`include "p0g_defs.svh"

package p0g_pkg;

    typedef logic [`P0G_NPINS-1:0] p0g_bits_t;
    typedef logic [`P0G_AW-1:0]    p0g_addr_t;
    typedef logic [31:0]           p0g_word_t;

endpackage : p0g_pkg

// ### design/p0g_edge_det.sv
/*
 * one pin's synchroniser and valid-edge detector.
 * assumes pin_i is asynchronous to clk_i; rst_i synchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none

module p0g_edge_det (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic en_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      level_o,
    output logic      pulse_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic pulse_q;

    // ****************************************
    // synchroniser
    // ****************************************
    // meta_q feeds sync_q only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
            last_q <= 1'h0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // ****************************************
    // edge detection
    // ****************************************
    // one pulse per edge; disabled pins never fire
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_q <= 1'h0;
        end else begin
            pulse_q <= en_i & ((rise_en_i & sync_q & ~last_q)
                             | (fall_en_i & ~sync_q & last_q));
        end
    end

    assign level_o = sync_q;
    assign pulse_o = pulse_q;

endmodule : p0g_edge_det

`default_nettype wire

// ### verification/p0g_port_monitor.sv
/* checker of the port block's bus and pin outputs.
   assumes it is bound to p0g_port, one clock. */
`timescale 1ns/1ps
`default_nettype none
module p0g_port_monitor (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire p0g_pkg::p0g_word_t dat_o,
    input wire logic               ack_o,
    input wire p0g_pkg::p0g_bits_t pin_i,
    input wire p0g_pkg::p0g_bits_t pin_oe_o,
    input wire p0g_pkg::p0g_bits_t pullup_en_o,
    input wire p0g_pkg::p0g_bits_t ext_irq_pulse_o,
    input wire logic               serial_rx_o,
    input wire logic               irq_o
);
    import p0g_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_RST: assert property (
        $fell(rst_i) |-> !pin_oe_o && !pullup_en_o && !ext_irq_pulse_o && serial_rx_o && !irq_o)
        else $error("outputs not idle after reset");
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_SRC: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without request");
    AST_DAT: assert property ($changed(dat_o) |-> ack_o && !we_i && dat_o[31:7] == 0)
        else $error("read data changed outside a read");
    AST_OE: assert property ($changed(pin_oe_o) |-> $past(ack_o && we_i))
        else $error("drive enable changed without a write");
    AST_PU: assert property ($changed(pullup_en_o) |-> $past(ack_o && we_i))
        else $error("pull-up changed without a write");
    AST_PULSE_ONE: assert property ((ext_irq_pulse_o & $past(ext_irq_pulse_o)) == 0)
        else $error("request pulse wider than one cycle");
    AST_PULSE_SRC: assert property (
        (ext_irq_pulse_o & ~($past(pin_i, 3) ^ $past(pin_i, 4))) == 0)
        else $error("request pulse without a pin edge");
endmodule : p0g_port_monitor
bind p0g_port p0g_port_monitor p0g_port_monitor_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
    .ack_o, .pin_i, .pin_oe_o, .pullup_en_o, .ext_irq_pulse_o, .serial_rx_o, .irq_o);
`default_nettype wire

// ### verification/p0g_pin_model.sv
/* outside world of the port pins: sources, pull-ups, pad drive.
   assumes the block's pad outputs; a floating pin flips each cycle. */
`timescale 1ns/1ps
`default_nettype none
module p0g_pin_model (
    input  wire logic               clk_i,
    input  wire p0g_pkg::p0g_bits_t drv_i,
    input  wire p0g_pkg::p0g_bits_t ext_en_i,
    input  wire p0g_pkg::p0g_bits_t pin_o,
    input  wire p0g_pkg::p0g_bits_t pin_oe_o,
    input  wire p0g_pkg::p0g_bits_t pullup_en_o,
    output p0g_pkg::p0g_bits_t      pin_i
);
    import p0g_pkg::*;
    p0g_bits_t last_q = '0;
    // pad drive wins over an outside source, pull-up over nothing
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_i[i] = pin_oe_o[i] ? pin_o[i] : ext_en_i[i] ? drv_i[i] : pullup_en_o[i] | ~last_q[i];
        end
    end
    always @(posedge clk_i) begin
        last_q <= pin_i;
    end
endmodule : p0g_pin_model
`default_nettype wire

// ### verification/p0g_port_test.sv
/* self-checking bench of p0g_port over wishbone.
   assumes p0g_pkg compiled first and defs on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "p0g_defs.svh"
module p0g_port_test;
    import p0g_pkg::*;
    typedef struct {p0g_addr_t a; p0g_word_t w; p0g_word_t e;} p0g_row_t;
    logic       clk_i = 0;
    logic       rst_i = 1;
    logic       cyc_i = 0;
    logic       stb_i = 0;
    logic       we_i = 0;
    logic [3:0] sel_i = 4'hf;
    p0g_addr_t  adr_i = '0;
    p0g_word_t  dat_i = '0;
    p0g_word_t  dat_o, rv;
    logic       ack_o, serial_rx_o, sampling_clock_o, irq_o;
    p0g_bits_t  pin_i, pin_o, pin_oe_o, pullup_en_o, ext_irq_pulse_o;
    p0g_bits_t  drv = '0;
    int         n_fail = 0;
    int         num_checks = 0;
    int         cnt[7];
    int         exp_c[7] = '{1, 1, 2, 0, 0, 0, 0};
    p0g_row_t   rows[10] = '{'{`P0G_OFS_DIR, 32'h2a, 32'h2a}, '{`P0G_OFS_PULLUP, 32'h7f, 32'h7f},
        '{`P0G_OFS_MODE, 32'h15, 32'h15}, '{`P0G_OFS_OUT, 32'hffffffff, 32'h7f}, '{`P0G_OFS_RISE, 32'h5a, 32'h5a},
        '{`P0G_OFS_FALL, 32'h33, 32'h33}, '{`P0G_OFS_RXSEL, 32'hff, 32'h01}, '{`P0G_OFS_MASK, 32'h0, 32'h0},
        '{`P0G_OFS_STAT, 32'h7f, 32'h0}, '{6'h28, 32'hff, 32'h0}};
    always #25 clk_i = ~clk_i;
    p0g_port p0g_port_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .ext_irq_pulse_o, .serial_rx_o, .sampling_clock_o, .irq_o);
    p0g_pin_model p0g_pin_model_inst (.clk_i, .drv_i(drv), .ext_en_i(7'h7f), .pin_o, .pin_oe_o,
        .pullup_en_o, .pin_i);
    always @(posedge clk_i) begin
        for (int i = 0; i < 7; i++) begin
            if (ext_irq_pulse_o[i] === 1'b1) cnt[i]++;
        end
    end
    // ****************************************
    // bus cycles and compares
    // ****************************************
    // the master waits for ack, never a fixed count
    task automatic wb(input logic w, input p0g_addr_t a, input p0g_word_t d);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        @(posedge clk_i);
        // only the watchdog ends a wait that never sees ack
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rv = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input p0g_addr_t a, input p0g_word_t d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rd(input p0g_addr_t a);
        wb(1'b0, a, '0);
    endtask : rd
    task automatic chk(input string nm, input p0g_word_t e, input p0g_word_t s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        #(50 * 3000);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("oe", 0, pin_oe_o);
        chk("rx", 1, serial_rx_o);
        for (int a = 0; a <= 36; a += 4) begin
            rd(p0g_addr_t'(a));
            if (a != 16) chk("reset reg", a == 0 ? 32'h7f : 32'h0, rv);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk("reg", rows[i].e, rv);
        end
        chk("oe", 32'h40, pin_oe_o);
        chk("pullup", 32'h7f, pullup_en_o);
        wr(`P0G_OFS_MODE, 32'h0);
        wr(`P0G_OFS_DIR, 32'h0);
        wr(`P0G_OFS_OUT, 32'h55);
        repeat (3) @(posedge clk_i);
        rd(`P0G_OFS_PIN);
        chk("pin", 32'h55, rv);
        sel_i <= 4'he;
        wr(`P0G_OFS_DIR, 32'h7f);
        sel_i <= 4'hf;
        chk("sel", 32'h7f, pin_oe_o);
        // bit4 stays in port mode, so its rise enable must do nothing
        wr(`P0G_OFS_DIR, 32'h7f);
        wr(`P0G_OFS_MODE, 32'h6f);
        wr(`P0G_OFS_RISE, 32'h15);
        wr(`P0G_OFS_FALL, 32'h06);
        repeat (5) @(posedge clk_i);
        cnt = '{default: 0};
        drv <= 7'h7f;
        repeat (10) @(posedge clk_i);
        drv <= 7'h00;
        repeat (10) @(posedge clk_i);
        for (int i = 0; i < 7; i++) chk("pulses", exp_c[i], cnt[i]);
        rd(`P0G_OFS_STAT);
        chk("stat", 32'h07, rv);
        chk("irq", 0, irq_o);
        wr(`P0G_OFS_MASK, 32'h02);
        chk("irq", 1, irq_o);
        wr(`P0G_OFS_STAT, 32'h02);
        chk("irq", 0, irq_o);
        rd(`P0G_OFS_STAT);
        chk("stat", 32'h05, rv);
        drv <= 7'h40;
        repeat (6) @(posedge clk_i);
        wr(`P0G_OFS_RXSEL, 32'h0);
        // rx output is registered, one edge behind the select
        @(posedge clk_i);
        chk("rx", 0, serial_rx_o);
        chk("smp", 0, sampling_clock_o);
        wr(`P0G_OFS_RXSEL, 32'h1);
        @(posedge clk_i);
        chk("rx", 1, serial_rx_o);
        drv <= 7'h20;
        repeat (6) @(posedge clk_i);
        chk("smp", 1, sampling_clock_o);
        chk("rx", 0, serial_rx_o);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("oe", 0, pin_oe_o);
        chk("pullup", 0, pullup_en_o);
        rd(`P0G_OFS_MODE);
        chk("mode", 0, rv);
        conclude();
    end
endmodule : p0g_port_test
`default_nettype wire
